// ---- logic/i2c_reg_slave.sv ----
// register slave end of the two-wire link, clocked by the serial clock
`timescale 1ns/100ps
// How it works
// - target only, never drives clock or starts
// - decode 7-bit address, own or general call
// - works at 100 kHz and 400 kHz
// - own address fixed at 0011000
// - lines only pulled low or released
// - eight-bit units, sampled on clock high
// - data edge with clock high is start/stop
// - detect both start and stop
// - master sends address plus direction bit
// - device acks each addressed byte
// - device drives data only during reads
// - master acks each byte it reads except the last, which it nacks
// - released line on ack slot means nack
// - stop idles bus; start restarts address phase
// - acknowledge general call address 00h
// - write pointer auto-increments per byte
// - acked read continues with next register
// - reset held low at least 10 ns
// - register contents survive, never cleared by logic
module i2c_reg_slave (
  input wire logic clock_i, // user-side clock
  input wire logic nrst_i, // asynchronous reset, active low
  i2c_if.dev bus, // two-wire link, slave side
  output logic busy_o, // high from a start until a stop
  output logic stop_o, // one-cycle pulse after each stop
  output logic wr_valid_o, // one-cycle pulse per register written
  output logic [7:0] wr_addr_o, // register index of the last write
  output logic [7:0] wr_data_o // value of the last write
);

  typedef enum logic [3:0] {
    SL_IDLE,
    SL_ADDR,
    SL_ADDR_ACK,
    SL_PTR,
    SL_PTR_ACK,
    SL_WDATA,
    SL_WDATA_ACK,
    SL_RDATA,
    SL_RDATA_ACK
  } slv_state_t;

  typedef struct packed {
    slv_state_t st;
    logic [2:0] cnt;
    logic [7:0] sr;
    logic [7:0] ptr;
    logic rd;
    logic gc;
    logic start_seen;
    logic sda_oe;
    logic wr_tgl;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } link_t;

  typedef struct packed {
    logic [1:0] start_sync;
    logic [1:0] stop_sync;
    logic [1:0] wr_sync;
    logic start_last;
    logic stop_last;
    logic wr_last;
    logic busy;
    logic stop_p;
    logic wr_valid;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } user_t;

  link_t l_q;
  link_t l_d;
  user_t u_q;
  user_t u_d;
  logic start_tgl_q;
  logic stop_tgl_q;
  logic bit_q;
  logic mem_we;
  logic [7:0] mem [i2c_pkg::REG_COUNT];

  // start: data falls while clock high; stop: data rises while clock high
  always_ff @(negedge bus.sda or negedge nrst_i) begin
    if (!nrst_i) begin
      start_tgl_q <= 1'b0;
    end else if (bus.scl) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  always_ff @(negedge nrst_i or posedge bus.sda) begin
    if (!nrst_i) begin
      stop_tgl_q <= 1'b0;
    end else if (bus.scl) begin
      stop_tgl_q <= ~stop_tgl_q;
    end
  end

  // data is settled by the time the clock rises
  always_ff @(posedge bus.scl or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_q <= 1'b0;
    end else begin
      bit_q <= bus.sda;
    end
  end

  // bit processing and data drive happen on the falling clock, so the
  // line only changes while the clock is low; the start toggle settled
  // a quarter of a serial period earlier, so it is read here without a synchroniser
  always_comb begin
    logic [7:0] byte_in;
    logic [7:0] rd_byte;
    byte_in = {l_q.sr[6:0], bit_q};
    rd_byte = mem[l_q.ptr];
    l_d = l_q;
    mem_we = 1'b0;
    if (start_tgl_q != l_q.start_seen) begin
      // a start while active is a repeated start: back to the address phase
      l_d.start_seen = start_tgl_q;
      l_d.st = SL_ADDR;
      l_d.cnt = 3'h0;
      l_d.sda_oe = 1'b0;
    end else begin
      unique case (l_q.st)
        SL_IDLE: begin
          l_d.sda_oe = 1'b0;
        end
        SL_ADDR: begin
          l_d.sr = byte_in;
          l_d.cnt = l_q.cnt + 3'h1;
          if (l_q.cnt == i2c_pkg::LAST_DATA_BIT) begin
            if (byte_in[7:1] == i2c_pkg::DEV_ADDR || byte_in == i2c_pkg::GC_BYTE) begin
              l_d.sda_oe = 1'b1;
              l_d.rd = byte_in[0];
              l_d.gc = (byte_in == i2c_pkg::GC_BYTE);
              l_d.st = SL_ADDR_ACK;
            end else begin
              l_d.st = SL_IDLE;
            end
          end
        end
        SL_ADDR_ACK: begin
          l_d.cnt = 3'h0;
          if (l_q.rd) begin
            // reads start from the current pointer
            l_d.sr = rd_byte;
            l_d.sda_oe = ~rd_byte[7];
            l_d.st = SL_RDATA;
          end else begin
            l_d.sda_oe = 1'b0;
            l_d.st = l_q.gc ? SL_WDATA : SL_PTR;
          end
        end
        SL_PTR: begin
          l_d.sr = byte_in;
          l_d.cnt = l_q.cnt + 3'h1;
          if (l_q.cnt == i2c_pkg::LAST_DATA_BIT) begin
            l_d.ptr = byte_in;
            l_d.sda_oe = 1'b1;
            l_d.st = SL_PTR_ACK;
          end
        end
        SL_WDATA: begin
          l_d.sr = byte_in;
          l_d.cnt = l_q.cnt + 3'h1;
          if (l_q.cnt == i2c_pkg::LAST_DATA_BIT) begin
            // general-call payload is acknowledged but not stored
            if (!l_q.gc) begin
              mem_we = 1'b1;
              l_d.wr_addr = l_q.ptr;
              l_d.wr_data = byte_in;
              l_d.wr_tgl = ~l_q.wr_tgl;
              l_d.ptr = l_q.ptr + 8'h01;
            end
            l_d.sda_oe = 1'b1;
            l_d.st = SL_WDATA_ACK;
          end
        end
        SL_PTR_ACK, SL_WDATA_ACK: begin
          l_d.sda_oe = 1'b0;
          l_d.cnt = 3'h0;
          l_d.st = SL_WDATA;
        end
        SL_RDATA: begin
          l_d.cnt = l_q.cnt + 3'h1;
          if (l_q.cnt == i2c_pkg::LAST_DATA_BIT) begin
            // release for the master's acknowledge
            l_d.sda_oe = 1'b0;
            l_d.ptr = l_q.ptr + 8'h01;
            l_d.st = SL_RDATA_ACK;
          end else begin
            l_d.sda_oe = ~l_q.sr[6];
            l_d.sr = {l_q.sr[6:0], 1'b0};
          end
        end
        SL_RDATA_ACK: begin
          l_d.cnt = 3'h0;
          if (!bit_q) begin
            l_d.sr = rd_byte;
            l_d.sda_oe = ~rd_byte[7];
            l_d.st = SL_RDATA;
          end else begin
            l_d.sda_oe = 1'b0;
            l_d.st = SL_IDLE;
          end
        end
        default: begin
          l_d.sda_oe = 1'b0;
          l_d.st = SL_IDLE;
        end
      endcase
    end
  end

  always_ff @(negedge bus.scl or negedge nrst_i) begin
    if (!nrst_i) begin
      l_q <= '{st: SL_IDLE, ptr: i2c_pkg::PTR_RESET, default: '0};
    end else begin
      l_q <= l_d;
    end
  end

  // storage has no reset: contents hold while supply stays up
  always_ff @(negedge bus.scl) begin
    if (mem_we) begin
      mem[l_q.ptr] <= {l_q.sr[6:0], bit_q};
    end
  end

  // the device never pulls the clock and only ever pulls data low
  assign bus.s_sda_o = 1'b0;
  assign bus.s_sda_oe = l_q.sda_oe;

  // user side: events cross as toggles; write address and data are held
  // for a whole byte time, so they are stable when the toggle arrives
  always_comb begin
    u_d = u_q;
    u_d.start_sync = {u_q.start_sync[0], start_tgl_q};
    u_d.stop_sync = {u_q.stop_sync[0], stop_tgl_q};
    u_d.wr_sync = {u_q.wr_sync[0], l_q.wr_tgl};
    u_d.start_last = u_q.start_sync[1];
    u_d.stop_last = u_q.stop_sync[1];
    u_d.wr_last = u_q.wr_sync[1];
    u_d.stop_p = u_q.stop_sync[1] != u_q.stop_last;
    u_d.wr_valid = u_q.wr_sync[1] != u_q.wr_last;
    if (u_q.start_sync[1] != u_q.start_last) begin
      u_d.busy = 1'b1;
    end else if (u_q.stop_sync[1] != u_q.stop_last) begin
      u_d.busy = 1'b0;
    end
    if (u_q.wr_sync[1] != u_q.wr_last) begin
      u_d.wr_addr = l_q.wr_addr;
      u_d.wr_data = l_q.wr_data;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      u_q <= '0;
    end else begin
      u_q <= u_d;
    end
  end

  assign busy_o = u_q.busy;
  assign stop_o = u_q.stop_p;
  assign wr_valid_o = u_q.wr_valid;
  assign wr_addr_o = u_q.wr_addr;
  assign wr_data_o = u_q.wr_data;

endmodule : i2c_reg_slave

// ---- logic/i2c_pkg.sv ----
// shared constants for the two-wire register link
package i2c_pkg;

  // target address of the register slave, and the general-call byte
  localparam logic [6:0] DEV_ADDR = 7'h18;
  localparam logic [7:0] GC_BYTE = 8'h00;

  // register file depth, one byte each, addressed by an 8-bit pointer
  localparam int REG_COUNT = 256;
  localparam logic [7:0] PTR_RESET = 8'h00;

  // bit slot layout: eight data bits, then the acknowledge bit
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // user clock and the two serial clock ceilings
  localparam int CLK_HZ = 10_000_000;
  localparam int STD_HZ = 100_000;
  localparam int FAST_HZ = 400_000;

  // each serial period is four quarters; round up so the rate never exceeds the ceiling
  localparam logic [7:0] QTR_STD = 8'((CLK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ));
  localparam logic [7:0] QTR_FAST = 8'((CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ));

  // least width of the low reset pulse after power-up
  localparam int RST_MIN_NS = 10;
  localparam int RST_MIN_CYC = ((RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000) < 1 ? 1 :
                               ((RST_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

endpackage : i2c_pkg

// ---- logic/i2c_if.sv ----
// open-drain two-wire link joining the host and the register slave
`timescale 1ns/100ps
interface i2c_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // pull-ups give the high level; any enabled low driver wins
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport dev (
    input scl,
    input sda,
    output s_sda_o,
    output s_sda_oe
  );

  modport host (
    input sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe
  );
endinterface : i2c_if

// ---- logic/i2c_host.sv ----
// bus master end of the two-wire link: register write and read sequences
`timescale 1ns/100ps
module i2c_host (
  input wire logic clock_i, // system clock
  input wire logic nrst_i, // asynchronous reset, active low
  i2c_if.host bus, // two-wire link, master side
  input wire logic fast_i, // 1: fast rate, 0: standard rate
  input wire logic cmd_valid_i, // start a transfer when ready
  input wire logic cmd_write_i, // 1: register write, 0: register read
  input wire logic [6:0] cmd_target_i, // target address
  input wire logic [7:0] cmd_reg_i, // first register index
  input wire logic [3:0] cmd_len_i, // data bytes to move
  input wire logic [7:0] tx_byte_i, // next byte to write
  output logic cmd_ready_o, // idle, accepts a command
  output logic tx_take_o, // pulse: tx_byte_i was taken
  output logic [7:0] rx_byte_o, // last byte read
  output logic rx_valid_o, // pulse: rx_byte_o is new
  output logic done_o, // pulse: stop sent
  output logic nack_o // last transfer ended on a nack
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} host_state_t;
  typedef enum logic [2:0] {R_ADDR_W, R_REG, R_WDATA, R_ADDR_R, R_RDATA} role_t;

  typedef struct packed {
    host_state_t st;
    role_t role;
    logic [1:0] phase;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [7:0] sr;
    logic [3:0] left;
    logic wr;
    logic fast;
    logic [6:0] target;
    logic [7:0] regb;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] sda_sync;
    logic ackbit;
    logic ready;
    logic nack;
    logic done;
    logic take;
    logic rx_valid;
    logic [7:0] rx_byte;
  } host_t;

  host_t h_q;
  host_t h_d;

  always_comb begin
    logic tick;
    tick = (h_q.div == 8'h00);
    h_d = h_q;
    h_d.sda_sync = {h_q.sda_sync[0], bus.sda};
    h_d.done = 1'b0;
    h_d.take = 1'b0;
    h_d.rx_valid = 1'b0;
    // quarter-period divider; no clock stretching is honoured
    h_d.div = tick ? ((h_q.fast ? i2c_pkg::QTR_FAST : i2c_pkg::QTR_STD) - 8'h01) :
              (h_q.div - 8'h01);
    if (h_q.st != H_IDLE && tick) begin
      h_d.phase = h_q.phase + 2'h1;
    end
    unique case (h_q.st)
      H_IDLE: begin
        h_d.phase = 2'h0;
        if (cmd_valid_i) begin
          h_d.st = H_START;
          h_d.ready = 1'b0;
          h_d.nack = 1'b0;
          h_d.role = R_ADDR_W;
          h_d.wr = cmd_write_i;
          h_d.fast = fast_i;
          h_d.target = cmd_target_i;
          h_d.regb = cmd_reg_i;
          h_d.left = (cmd_write_i || cmd_len_i != 4'h0) ? cmd_len_i : 4'h1;
          h_d.sr = {cmd_target_i, 1'b0};
        end
      end
      H_START: begin
        if (tick) begin
          unique case (h_q.phase)
            2'h0: h_d.sda_oe = 1'b0;
            2'h1: h_d.scl_oe = 1'b0;
            2'h2: h_d.sda_oe = 1'b1;
            2'h3: begin
              h_d.scl_oe = 1'b1;
              h_d.bitn = 4'h0;
              h_d.st = H_BYTE;
            end
          endcase
        end
      end
      H_BYTE: begin
        if (tick) begin
          unique case (h_q.phase)
            2'h0: begin
              // data only changes with the clock low
              if (h_q.bitn == i2c_pkg::ACK_SLOT) begin
                h_d.sda_oe = (h_q.role == R_RDATA) && (h_q.left != 4'h1);
              end else begin
                h_d.sda_oe = (h_q.role != R_RDATA) && !h_q.sr[7];
              end
            end
            2'h1: h_d.scl_oe = 1'b0;
            2'h2: begin
              if (h_q.bitn == i2c_pkg::ACK_SLOT) begin
                h_d.ackbit = h_q.sda_sync[1];
              end else begin
                h_d.sr = {h_q.sr[6:0], h_q.sda_sync[1]};
              end
            end
            2'h3: begin
              h_d.scl_oe = 1'b1;
              h_d.bitn = h_q.bitn + 4'h1;
              if (h_q.bitn == i2c_pkg::ACK_SLOT) begin
                h_d.bitn = 4'h0;
                if (h_q.role != R_RDATA && h_q.ackbit) begin
                  h_d.nack = 1'b1;
                  h_d.st = H_STOP;
                end else begin
                  unique case (h_q.role)
                    R_ADDR_W: begin
                      h_d.role = R_REG;
                      h_d.sr = h_q.regb;
                    end
                    R_REG: begin
                      if (!h_q.wr) begin
                        h_d.role = R_ADDR_R;
                        h_d.sr = {h_q.target, 1'b1};
                        h_d.st = H_START;
                      end else if (h_q.left == 4'h0) begin
                        h_d.st = H_STOP;
                      end else begin
                        h_d.role = R_WDATA;
                        h_d.sr = tx_byte_i;
                        h_d.take = 1'b1;
                      end
                    end
                    R_WDATA: begin
                      h_d.left = h_q.left - 4'h1;
                      if (h_q.left == 4'h1) begin
                        h_d.st = H_STOP;
                      end else begin
                        h_d.sr = tx_byte_i;
                        h_d.take = 1'b1;
                      end
                    end
                    R_ADDR_R: h_d.role = R_RDATA;
                    R_RDATA: begin
                      h_d.rx_byte = h_q.sr;
                      h_d.rx_valid = 1'b1;
                      h_d.left = h_q.left - 4'h1;
                      if (h_q.left == 4'h1) begin
                        h_d.st = H_STOP;
                      end
                    end
                    default: h_d.st = H_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          unique case (h_q.phase)
            2'h0: h_d.sda_oe = 1'b1;
            2'h1: h_d.scl_oe = 1'b0;
            2'h2: h_d.sda_oe = 1'b0;
            2'h3: begin
              h_d.st = H_IDLE;
              h_d.ready = 1'b1;
              h_d.done = 1'b1;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      h_q <= '{st: H_IDLE, role: R_ADDR_W, ready: 1'b1, default: '0};
    end else begin
      h_q <= h_d;
    end
  end

  // open drain: only ever pull low
  assign bus.m_scl_o = 1'b0;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_scl_oe = h_q.scl_oe;
  assign bus.m_sda_oe = h_q.sda_oe;
  assign cmd_ready_o = h_q.ready;
  assign tx_take_o = h_q.take;
  assign rx_byte_o = h_q.rx_byte;
  assign rx_valid_o = h_q.rx_valid;
  assign done_o = h_q.done;
  assign nack_o = h_q.nack;

endmodule : i2c_host

// ---- tb/i2c_link_sva.sv ----
// checker for the open-drain two-wire link between host and register slave
`timescale 1ns/100ps
module i2c_link_sva (
  input wire logic clock_i, // host clock, samples the link
  input wire logic nrst_i, // asynchronous reset, active low
  input wire logic m_scl_o, // host clock level when enabled
  input wire logic m_scl_oe, // host pulls the clock low
  input wire logic m_sda_o, // host data level when enabled
  input wire logic m_sda_oe, // host pulls the data low
  input wire logic s_sda_o, // slave data level when enabled
  input wire logic s_sda_oe, // slave pulls the data low
  input wire logic scl, // resolved clock line
  input wire logic sda // resolved data line
);
  logic scl_q, sda_q, rd_q, wr_q, gone_q, seen_q;
  logic [3:0] cnt_q;
  logic [3:0] byte_q;
  logic [7:0] sh_q;
  logic [7:0] per_q;
  logic start_w, stop_w, rise_w, hit_w;

  assign start_w = scl && scl_q && sda_q && !sda;
  assign stop_w = scl && scl_q && !sda_q && sda;
  assign rise_w = scl && !scl_q;
  assign hit_w = (sh_q[7:1] == i2c_pkg::DEV_ADDR) || (sh_q == i2c_pkg::GC_BYTE);

  // the host makes the clock from clock_i flops and the slave moves data only on its falling edge, so plain sampling sees every edge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      {rd_q, wr_q, gone_q, seen_q} <= 4'h0;
      cnt_q <= 4'h0;
      byte_q <= 4'h0;
      sh_q <= 8'h00;
      per_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      per_q <= rise_w ? 8'h00 : (per_q == 8'hFF ? per_q : per_q + 8'h01);
      if (rise_w) seen_q <= 1'b1;
      if (start_w || stop_w) begin
        {rd_q, wr_q, gone_q} <= 3'h0;
        cnt_q <= 4'h0;
        byte_q <= 4'h0;
      end else if (rise_w && cnt_q == i2c_pkg::ACK_SLOT) begin
        cnt_q <= 4'h0;
        byte_q <= byte_q + {3'h0, byte_q != 4'hF};
        if (byte_q == 4'h0) rd_q <= hit_w && sh_q[0];
        if (byte_q == 4'h0) wr_q <= hit_w && !sh_q[0];
        if (rd_q && sda && byte_q != 4'h0) gone_q <= 1'b1;
      end else if (rise_w) begin
        cnt_q <= cnt_q + 4'h1;
        sh_q <= {sh_q[6:0], sda};
      end
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_ack_rise;
    rise_w && cnt_q == i2c_pkg::ACK_SLOT;
  endsequence
  sequence s_addr_ack;
    s_ack_rise ##0 byte_q == 4'h0;
  endsequence

  a_open_drain_only: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
    else $error("a line was driven high");
  a_slave_edge_low: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave moved data while clock high");
  a_host_edge_framed: assert property ($changed(m_sda_oe) && scl |-> start_w || stop_w)
    else $error("host data moved with clock high outside start or stop");
  a_stop_then_idle: assert property (stop_w |=> (scl && sda) [*4])
    else $error("bus not idle after stop");
  a_addr_ack_match: assert property (s_addr_ack |-> sda == !hit_w)
    else $error("address acknowledge does not match decode");
  a_write_byte_ack: assert property (s_ack_rise ##0 (byte_q != 4'h0 && wr_q) |-> !sda)
    else $error("written byte not acknowledged");
  a_read_only_drive: assert property (s_sda_oe && rise_w && cnt_q != i2c_pkg::ACK_SLOT |-> rd_q)
    else $error("slave drove a data bit outside a read");
  a_nack_release: assert property (gone_q |-> !s_sda_oe)
    else $error("slave kept data after host nack");
  a_rate_limit: assert property (rise_w && seen_q |-> per_q >= 8'h18)
    else $error("serial clock faster than fast mode");
  a_clock_high_hold: assert property ($rose(scl) |-> scl [*6])
    else $error("clock high pulse too short to capture a bit");
endmodule : i2c_link_sva

// ---- tb/i2c_slave_register_access_test.sv ----
// testbench: host and register slave joined over the two-wire link
`timescale 1ns/100ps
module i2c_slave_register_access_test;
  localparam int LIMIT = 20000; // cycles; the run needs about 8500
  logic clock_i, nrst_i, fast_i, cmd_valid_i, cmd_write_i;
  logic [6:0] cmd_target_i;
  logic [7:0] cmd_reg_i, tx_byte_i, rx_byte_o, wr_addr_o, wr_data_o;
  logic [3:0] cmd_len_i;
  logic cmd_ready_o, tx_take_o, rx_valid_o, done_o, nack_o, busy_o, stop_o, wr_valid_o;
  int miscompares, compares, cycles, stops, xfers;
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic [15:0] wq[$];

  i2c_if bus_if();
  i2c_host i2c_host_i(.clock_i(clock_i), .nrst_i(nrst_i), .bus(bus_if.host), .fast_i(fast_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_target_i(cmd_target_i),
    .cmd_reg_i(cmd_reg_i), .cmd_len_i(cmd_len_i), .tx_byte_i(tx_byte_i),
    .cmd_ready_o(cmd_ready_o), .tx_take_o(tx_take_o), .rx_byte_o(rx_byte_o),
    .rx_valid_o(rx_valid_o), .done_o(done_o), .nack_o(nack_o));
  i2c_reg_slave i2c_reg_slave_i(.clock_i(clock_i), .nrst_i(nrst_i), .bus(bus_if.dev),
    .busy_o(busy_o), .stop_o(stop_o), .wr_valid_o(wr_valid_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o));
  i2c_link_sva i2c_link_sva_i(.clock_i(clock_i), .nrst_i(nrst_i), .m_scl_o(bus_if.m_scl_o),
    .m_scl_oe(bus_if.m_scl_oe), .m_sda_o(bus_if.m_sda_o), .m_sda_oe(bus_if.m_sda_oe),
    .s_sda_o(bus_if.s_sda_o), .s_sda_oe(bus_if.s_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));

  task automatic cmp1(input logic a, input logic e);
    compares++;
    if (a !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
    end
  endtask : cmp1
  task automatic cmp8(input logic [7:0] a, input logic [7:0] e);
    compares++;
    if (a !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
    end
  endtask : cmp8
  task automatic cmp16(input logic [15:0] a, input logic [15:0] e);
    compares++;
    if (a !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, a, e);
    end
  endtask : cmp16

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // one command; write bytes follow tx_take_o, read bytes are checked as they land
  task automatic xfer(input logic w, input logic [6:0] tgt, input logic [7:0] rg,
                      input logic [3:0] n, input logic f);
    int k;
    @(posedge clock_i);
    cmd_write_i <= w;
    cmd_target_i <= tgt;
    cmd_reg_i <= rg;
    cmd_len_i <= n;
    fast_i <= f;
    tx_byte_i <= txq.size() > 0 ? txq[0] : 8'h00;
    cmd_valid_i <= 1'b1;
    @(posedge clock_i);
    cmd_valid_i <= 1'b0;
    xfers++;
    for (k = 0; k < 40000; k++) begin
      @(negedge clock_i);
      if (k == 0) cmp1(cmd_ready_o, 1'b0);
      if (tx_take_o === 1'b1 || rx_valid_o === 1'b1) cmp1(busy_o, 1'b1);
      if (tx_take_o === 1'b1 && txq.size() > 0) void'(txq.pop_front());
      if (rx_valid_o === 1'b1) cmp8(rx_byte_o, rxq.size() > 0 ? rxq.pop_front() : 8'hXX);
      if (done_o === 1'b1) begin
        cmp1(cmd_ready_o, 1'b1);
        break;
      end
      @(posedge clock_i);
      tx_byte_i <= txq.size() > 0 ? txq[0] : 8'h00;
    end
  endtask : xfer

  task automatic wr(input logic [6:0] tgt, input logic [7:0] rg, input logic [3:0] n,
                    input logic f, input logic keep);
    int i;
    for (i = 0; i < int'(n); i++) begin
      if (keep) wq.push_back({rg + 8'(i), txq[i]});
    end
    xfer(1'b1, tgt, rg, n, f);
  endtask : wr

  // busy_o trails the stop by a few clocks, so let it settle first
  task automatic endt(input string name, input logic nk);
    repeat (8) @(negedge clock_i);
    cmp1(nack_o, nk);
    cmp1(busy_o, 1'b0);
    cmp8(8'(stops), 8'(xfers));
    cmp8(8'(wq.size() + rxq.size()), 8'h00);
    $display("test %s done", name);
  endtask : endt

  always @(negedge clock_i) begin
    if (stop_o === 1'b1) stops++;
    if (wr_valid_o === 1'b1 && wq.size() == 0) cmp1(wr_valid_o, 1'b0);
    else if (wr_valid_o === 1'b1) cmp16({wr_addr_o, wr_data_o}, wq.pop_front());
  end

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  initial begin
    nrst_i = 1'b1;
    fast_i = 1'b1;
    cmd_valid_i = 1'b0;
    cmd_write_i = 1'b0;
    cmd_target_i = 7'h00;
    cmd_reg_i = 8'h00;
    cmd_len_i = 4'h0;
    tx_byte_i = 8'h00;
    // a real falling edge, so flops clocked by the link see their reset
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    txq = '{8'hA1, 8'hB2, 8'hC3};
    wr(i2c_pkg::DEV_ADDR, 8'hFE, 4'h3, 1'b1, 1'b1);
    endt("wrap write", 1'b0);
    rxq = '{8'hA1, 8'hB2, 8'hC3};
    xfer(1'b0, i2c_pkg::DEV_ADDR, 8'hFE, 4'h3, 1'b1);
    endt("wrap read", 1'b0);
    txq = '{8'h5A};
    wr(i2c_pkg::DEV_ADDR, 8'h10, 4'h1, 1'b0, 1'b1);
    endt("standard write", 1'b0);
    txq = '{8'h55};
    wr(7'h19, 8'h10, 4'h1, 1'b1, 1'b0);
    endt("foreign write", 1'b1);
    xfer(1'b0, 7'h0C, 8'h10, 4'h1, 1'b1);
    endt("foreign read", 1'b1);
    txq = '{8'h66};
    wr(i2c_pkg::GC_BYTE[7:1], 8'h10, 4'h1, 1'b1, 1'b0);
    endt("general call", 1'b0);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    rxq = '{8'h5A};
    xfer(1'b0, i2c_pkg::DEV_ADDR, 8'h10, 4'h1, 1'b1);
    endt("kept after reset", 1'b0);
    conclude();
  end
endmodule : i2c_slave_register_access_test
